// ==== include/aip_map.vh ====
`ifndef AIP_MAP_VH
`define AIP_MAP_VH

// Register addresses on the processor's external-data space.
`define AIP_ADDR_PTR_HIGH   16'h7FE3
`define AIP_ADDR_PTR_LOW    16'h7FE4
`define AIP_ADDR_DATA_PORT  16'h7FE5

// Reset value chosen for the pointer, which the hardware leaves undefined.
`define AIP_PTR_RESET       16'h0000

// Internal program/data RAM window that the pointer may reach.
`define AIP_RAM_BASE        16'h0000
`define AIP_RAM_LAST        16'h1FFF

// Size of one bulk endpoint buffer in bytes.
`define AIP_EP_BUF_BYTES    7'h40

// FIFO geometry for the read-data path.
`define AIP_FIFO_WIDTH      8
`define AIP_FIFO_DEPTH      16
`define AIP_FIFO_AW         4

`endif

// ==== rtl/aip_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
module aip_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	input  wire             clk,
	input  wire             arst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage is written at the write index only.
	always @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// Pointers advance on each accepted transfer; the count moves only on a push or a pop alone.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/aip_ram_port.v ====
`timescale 1ns/1ps
`default_nettype none
module aip_ram_port (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        go,
	input  wire        go_write,
	input  wire [15:0] go_addr,
	input  wire [7:0]  go_wdata,
	output reg         ram_en_q,
	output reg         ram_we_q,
	output reg  [15:0] ram_addr_q,
	output reg  [7:0]  ram_wdata_q,
	output reg         rd_pend_q
);
	// One-cycle RAM strobe; a read marks its data due on the next cycle.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ram_en_q    <= 1'b0;
			ram_we_q    <= 1'b0;
			ram_addr_q  <= 16'h0000;
			ram_wdata_q <= 8'h00;
			rd_pend_q   <= 1'b0;
		end
		else
		begin
			ram_en_q  <= go;
			ram_we_q  <= go & go_write;
			rd_pend_q <= ram_en_q & ~ram_we_q;
			if (go)
			begin
				ram_addr_q  <= go_addr;
				ram_wdata_q <= go_wdata;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/aip_autoptr.v ====
// How it works
// - Software reaches a contiguous block of internal RAM through one data port, like a FIFO.
// - Each data port access uses the 16-bit pointer formed from the high and low bytes as its RAM address.
// - After each data port read or write that reaches the RAM the pointer goes up by one; a refused or dropped access leaves it.
// - Either pointer byte may be written at any time and the next data port access uses the new value.
// - Reading a pointer byte returns the live pointer, the address of the next data port access.
// - A bulk endpoint buffer is 64 bytes, so a full packet is 64 sequential data port accesses.
// - The pointer reaches internal program/data RAM only, never off-chip memory or freed isochronous RAM.
`timescale 1ns/1ps
`default_nettype none
`include "aip_map.vh"
module aip_autoptr (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        cpu_sel,
	input  wire        cpu_write,
	input  wire [15:0] cpu_addr,
	input  wire [7:0]  cpu_wdata,
	output reg  [7:0]  cpu_rdata_q,
	output reg         cpu_rvalid_q,
	output reg         cpu_busy_q,
	output wire        ram_en_q,
	output wire        ram_we_q,
	output wire [15:0] ram_addr_q,
	output wire [7:0]  ram_wdata_q,
	input  wire [7:0]  ram_rdata,
	output reg         range_err_q,
	output reg  [6:0]  burst_count_q
);
	// One-hot read sequencer states.
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_WAIT  = 3'b010;
	localparam [2:0] ST_DRAIN = 3'b100;

	// Registers and their next values.
	reg  [15:0] ptr_q;
	reg  [15:0] ptr_d;
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [7:0]  cpu_rdata_d;
	reg         cpu_rvalid_d;
	reg         cpu_busy_d;
	reg         range_err_d;
	reg  [6:0]  burst_count_d;

	// Decode and handshake nets.
	wire        hit_high;
	wire        hit_low;
	wire        hit_data;
	wire        wr_high;
	wire        wr_low;
	wire        rd_high;
	wire        rd_low;
	wire        ptr_load;
	wire        in_ram;
	wire        seq_idle;
	wire        seq_drain;
	wire        go;
	wire        go_read;
	wire        rd_pend_q;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [7:0]  fifo_out_data;
	wire        fifo_pop;

	// Address match against one mapped register.
	function hit;
		input [15:0] a;
		input [15:0] reg_addr;
		begin
			hit = (a == reg_addr);
		end
	endfunction

	// Pointer with one byte replaced by a processor write.
	function [15:0] ptr_with_byte;
		input [15:0] p;
		input [7:0]  b;
		input        high;
		begin
			ptr_with_byte = high ? {b, p[7:0]} : {p[15:8], b};
		end
	endfunction

	// Pointer after one data port access; the carry runs from the low byte into the high byte.
	function [15:0] ptr_next;
		input [15:0] p;
		begin
			ptr_next = p + 16'h0001;
		end
	endfunction

	// One byte of the live pointer for readback.
	function [7:0] ptr_byte;
		input [15:0] p;
		input        high;
		begin
			ptr_byte = high ? p[15:8] : p[7:0];
		end
	endfunction

	// Whether an address lies in internal RAM, whose window starts at the bottom of the space.
	function in_window;
		input [15:0] p;
		begin
			in_window = (p <= `AIP_RAM_LAST);
		end
	endfunction

	// Next burst count, which restarts at one after a full endpoint buffer.
	function [6:0] burst_next;
		input [6:0] c;
		begin
			burst_next = (c == `AIP_EP_BUF_BYTES) ? 7'h01 : c + 7'h01;
		end
	endfunction

	// Register decode on the processor strobe.
	assign hit_high = cpu_sel & hit(cpu_addr, `AIP_ADDR_PTR_HIGH);
	assign hit_low  = cpu_sel & hit(cpu_addr, `AIP_ADDR_PTR_LOW);
	assign hit_data = cpu_sel & hit(cpu_addr, `AIP_ADDR_DATA_PORT);

	// Pointer byte accesses split by direction.
	assign wr_high  = hit_high & cpu_write;
	assign wr_low   = hit_low & cpu_write;
	assign rd_high  = hit_high & ~cpu_write;
	assign rd_low   = hit_low & ~cpu_write;
	assign ptr_load = wr_high | wr_low;

	// Only addresses inside internal RAM are allowed onto the RAM port.
	assign in_ram = in_window(ptr_q);

	// Sequencer phase decode.
	assign seq_idle  = (state_q == ST_IDLE);
	assign seq_drain = (state_q == ST_DRAIN);

	// Data port access is started only when idle and the read FIFO has room.
	// An access while a read is in flight is dropped, so the processor must watch busy.
	assign go       = hit_data & seq_idle & fifo_in_ready & in_ram;
	assign go_read  = go & ~cpu_write;
	assign fifo_pop = fifo_out_valid & seq_drain;

	// Next pointer: byte writes replace it, data port accesses advance it.
	always @*
	begin
		ptr_d = ptr_q;
		if (wr_high)
			ptr_d = ptr_with_byte(ptr_q, cpu_wdata, 1'b1);
		else if (wr_low)
			ptr_d = ptr_with_byte(ptr_q, cpu_wdata, 1'b0);
		else if (go)
			ptr_d = ptr_next(ptr_q);
	end

	// Read transactions wait for RAM data, then hand it through the FIFO.
	// Writes never leave idle, so back-to-back data writes run at one per cycle.
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (go_read)
					state_d = ST_WAIT;
			ST_WAIT:
				if (rd_pend_q)
					state_d = ST_DRAIN;
			ST_DRAIN:
				if (fifo_pop)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// Read answer: pointer bytes show the live pointer, data port reads show buffered RAM data.
	// A pointer read that lands while a data read drains takes the answer slot and the data is lost.
	// The processor avoids this by waiting for busy to fall first.
	always @*
	begin
		cpu_rdata_d  = cpu_rdata_q;
		cpu_rvalid_d = 1'b0;
		if (rd_high)
		begin
			cpu_rdata_d  = ptr_byte(ptr_q, 1'b1);
			cpu_rvalid_d = 1'b1;
		end
		else if (rd_low)
		begin
			cpu_rdata_d  = ptr_byte(ptr_q, 1'b0);
			cpu_rvalid_d = 1'b1;
		end
		else if (fifo_pop)
		begin
			cpu_rdata_d  = fifo_out_data;
			cpu_rvalid_d = 1'b1;
		end
	end

	// Busy covers a read in flight; a refused access flags itself for one cycle.
	always @*
	begin
		cpu_busy_d  = (state_d != ST_IDLE);
		range_err_d = hit_data & ~in_ram;
	end

	// Counts accesses within one endpoint buffer; a pointer load restarts it.
	// The count only tracks traffic, it never blocks an access.
	always @*
	begin
		burst_count_d = burst_count_q;
		if (ptr_load)
			burst_count_d = 7'h00;
		else if (go)
			burst_count_d = burst_next(burst_count_q);
	end

	// Pointer register.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ptr_q <= `AIP_PTR_RESET;
		else
			ptr_q <= ptr_d;
	end

	// Sequencer state register.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Processor read answer registers.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpu_rdata_q  <= 8'h00;
			cpu_rvalid_q <= 1'b0;
		end
		else
		begin
			cpu_rdata_q  <= cpu_rdata_d;
			cpu_rvalid_q <= cpu_rvalid_d;
		end
	end

	// Status registers.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpu_busy_q  <= 1'b0;
			range_err_q <= 1'b0;
		end
		else
		begin
			cpu_busy_q  <= cpu_busy_d;
			range_err_q <= range_err_d;
		end
	end

	// Burst counter register.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			burst_count_q <= 7'h00;
		else
			burst_count_q <= burst_count_d;
	end

	// The RAM strobe uses the pointer value before its increment.
	// Write data and direction ride with the strobe so the RAM sees one coherent request.
	aip_ram_port u_ram (
		.clk         (clk),
		.arst_n      (arst_n),
		.go          (go),
		.go_write    (cpu_write),
		.go_addr     (ptr_q),
		.go_wdata    (cpu_wdata),
		.ram_en_q    (ram_en_q),
		.ram_we_q    (ram_we_q),
		.ram_addr_q  (ram_addr_q),
		.ram_wdata_q (ram_wdata_q),
		.rd_pend_q   (rd_pend_q)
	);

	// Read data buffer between the RAM and the processor.
	// It decouples the fixed RAM read latency from the answer slot on the processor side.
	aip_fifo #(
		.WIDTH (`AIP_FIFO_WIDTH),
		.DEPTH (`AIP_FIFO_DEPTH),
		.AW    (`AIP_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (rd_pend_q),
		.in_ready  (fifo_in_ready),
		.in_data   (ram_rdata),
		.out_valid (fifo_out_valid),
		.out_ready (seq_drain),
		.out_data  (fifo_out_data)
	);
endmodule
`default_nettype wire

// ==== testbench/aip_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aip_map.vh"
module aip_assertions (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        cpu_sel,
	input wire logic        cpu_write,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0]  cpu_wdata,
	input wire logic [7:0]  cpu_rdata_q,
	input wire logic        cpu_rvalid_q,
	input wire logic        cpu_busy_q,
	input wire logic        ram_en_q,
	input wire logic        ram_we_q,
	input wire logic [15:0] ram_addr_q,
	input wire logic [7:0]  ram_wdata_q,
	input wire logic [7:0]  ram_rdata,
	input wire logic        range_err_q,
	input wire logic [6:0]  burst_count_q
);
	// Accepted data port and pointer read requests.
	wire logic da = cpu_sel && !cpu_busy_q && cpu_addr == `AIP_ADDR_DATA_PORT;
	wire logic pr = cpu_sel && !cpu_write && !cpu_busy_q &&
		(cpu_addr == `AIP_ADDR_PTR_HIGH || cpu_addr == `AIP_ADDR_PTR_LOW);
	wire logic rd = ram_en_q && !ram_we_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_data_write: assert property (da && cpu_write |=> range_err_q || ram_we_q && ram_wdata_q == $past(cpu_wdata))
		else $error("data write lost");
	a_data_read: assert property (da && !cpu_write |=> range_err_q || rd)
		else $error("data read lost");
	a_read_answer: assert property (rd |-> ##3 cpu_rvalid_q)
		else $error("read answer late");
	a_read_busy: assert property (rd |-> cpu_busy_q)
		else $error("busy low in read");
	a_step_one: assert property (ram_en_q && $past(ram_en_q) |-> ram_addr_q == $past(ram_addr_q) + 16'h0001)
		else $error("pointer step wrong");
	a_ptr_answer: assert property (pr |=> cpu_rvalid_q)
		else $error("pointer read lost");
	a_ram_window: assert property (ram_en_q |-> ram_addr_q <= `AIP_RAM_LAST)
		else $error("RAM address out of window");
	a_err_quiet: assert property (range_err_q |-> !ram_en_q)
		else $error("refused access reached RAM");
	a_burst_max: assert property (burst_count_q <= 7'h40)
		else $error("burst count too high");
	// Main traffic kinds.
	c_write: cover property (ram_en_q && ram_we_q);
	c_read: cover property (rd ##3 cpu_rvalid_q);
	c_refuse: cover property (range_err_q);
endmodule
bind aip_autoptr aip_assertions u_chk (
	.clk           (clk),
	.arst_n        (arst_n),
	.cpu_sel       (cpu_sel),
	.cpu_write     (cpu_write),
	.cpu_addr      (cpu_addr),
	.cpu_wdata     (cpu_wdata),
	.cpu_rdata_q   (cpu_rdata_q),
	.cpu_rvalid_q  (cpu_rvalid_q),
	.cpu_busy_q    (cpu_busy_q),
	.ram_en_q      (ram_en_q),
	.ram_we_q      (ram_we_q),
	.ram_addr_q    (ram_addr_q),
	.ram_wdata_q   (ram_wdata_q),
	.ram_rdata     (ram_rdata),
	.range_err_q   (range_err_q),
	.burst_count_q (burst_count_q)
);
`default_nettype wire

// ==== testbench/aip_ram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aip_ram_model (
	input wire logic        clk,
	input wire logic        ram_en_q,
	input wire logic        ram_we_q,
	input wire logic [15:0] ram_addr_q,
	input wire logic [7:0]  ram_wdata_q,
	output logic     [7:0]  ram_rdata
);
	logic [7:0] mem [0:8191];
	logic [7:0] rdata_q = 8'h5A;
	assign ram_rdata = rdata_q;
	// Synchronous RAM, one cycle of latency; outside a read the data keeps toggling.
	always @(posedge clk)
	begin
		if (ram_en_q && ram_we_q)
			mem[ram_addr_q[12:0]] <= ram_wdata_q;
		rdata_q <= (ram_en_q && !ram_we_q) ? mem[ram_addr_q[12:0]] : ~rdata_q;
	end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aip_map.vh"
module testbench;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cpu_sel = 1'b0;
	logic        cpu_write = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0]  cpu_wdata = 8'h00;
	wire  [7:0]  cpu_rdata_q, ram_wdata_q, ram_rdata;
	wire         cpu_rvalid_q, cpu_busy_q, ram_en_q, ram_we_q, range_err_q;
	wire  [15:0] ram_addr_q;
	wire  [6:0]  burst_count_q;
	int          errors = 0;
	int          num_checks = 0;
	int          k;
	aip_autoptr u_dut (
		.clk           (clk),
		.arst_n        (arst_n),
		.cpu_sel       (cpu_sel),
		.cpu_write     (cpu_write),
		.cpu_addr      (cpu_addr),
		.cpu_wdata     (cpu_wdata),
		.cpu_rdata_q   (cpu_rdata_q),
		.cpu_rvalid_q  (cpu_rvalid_q),
		.cpu_busy_q    (cpu_busy_q),
		.ram_en_q      (ram_en_q),
		.ram_we_q      (ram_we_q),
		.ram_addr_q    (ram_addr_q),
		.ram_wdata_q   (ram_wdata_q),
		.ram_rdata     (ram_rdata),
		.range_err_q   (range_err_q),
		.burst_count_q (burst_count_q)
	);
	aip_ram_model u_ram (
		.clk         (clk),
		.ram_en_q    (ram_en_q),
		.ram_we_q    (ram_we_q),
		.ram_addr_q  (ram_addr_q),
		.ram_wdata_q (ram_wdata_q),
		.ram_rdata   (ram_rdata)
	);
	always #25 clk = ~clk;
	// Compares one value and reports a mismatch.
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		num_checks++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Starts one access at a falling edge; the strobe stays up for back-to-back writes.
	task automatic go(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		cpu_sel = 1'b1;
		cpu_write = w;
		cpu_addr = a;
		cpu_wdata = d;
	endtask
	task automatic idle;
		@(negedge clk);
		cpu_sel = 1'b0;
	endtask
	// Reads one register; the one-cycle answer is looked for from the falling edge right after the strobe.
	task automatic r(input logic [15:0] a, input logic [7:0] e);
		int i;
		logic seen;
		seen = 1'b0;
		go(1'b0, a, 8'h00);
		idle;
		for (i = 0; i < 9 && !seen; i++)
		begin
			if (cpu_rvalid_q === 1'b1)
			begin
				seen = 1'b1;
				chk("cpu_rdata_q", {8'h00, e}, {8'h00, cpu_rdata_q});
				chk("cpu_busy_q", 16'h0000, {15'h0000, cpu_busy_q});
			end
			else
				@(negedge clk);
		end
		if (!seen)
		begin
			errors++;
			end_of_test;
		end
	endtask
	task automatic pw(input logic [15:0] v);
		go(1'b1, `AIP_ADDR_PTR_HIGH, v[15:8]);
		go(1'b1, `AIP_ADDR_PTR_LOW, v[7:0]);
		idle;
	endtask
	task automatic p(input logic [15:0] v);
		r(`AIP_ADDR_PTR_HIGH, v[15:8]);
		r(`AIP_ADDR_PTR_LOW, v[7:0]);
	endtask
	// Main sequence: load, stream across a byte carry, read back, full packet, refused range.
	initial
	begin
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		pw(16'h01FE);
		p(16'h01FE);
		for (k = 0; k < 4; k++)
			go(1'b1, `AIP_ADDR_DATA_PORT, 8'hA0 + k[7:0]);
		idle;
		p(16'h0202);
		pw(16'h01FE);
		for (k = 0; k < 4; k++)
			r(`AIP_ADDR_DATA_PORT, 8'hA0 + k[7:0]);
		p(16'h0202);
		pw(16'h0400);
		for (k = 0; k < 64; k++)
			go(1'b1, `AIP_ADDR_DATA_PORT, k[7:0]);
		idle;
		chk("burst_count_q", 16'h0040, {9'h000, burst_count_q});
		p(16'h0440);
		pw(16'h043F);
		r(`AIP_ADDR_DATA_PORT, 8'h3F);
		pw(16'h2000);
		go(1'b1, `AIP_ADDR_DATA_PORT, 8'h55);
		idle;
		chk("range_err_q", 16'h0001, {15'h0000, range_err_q});
		p(16'h2000);
		idle;
		end_of_test;
	end
endmodule
`default_nettype wire
